// [core/frmw_page_buf.v]
// flip-flop byte store holding both page buffers
`include "frmw_defs.vh"
module frmw_page_buf #(
  parameter DEPTH = `FRMW_BUF_DEPTH,
  parameter AW = `FRMW_BUF_AW
) (
  // clock
  input wire mclk_in,
  // write port
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [7:0] wdata_in,
  // read port
  input wire [AW-1:0] raddr_in,
  output wire [7:0] rdata_out
);

  reg [7:0] mem [0:DEPTH-1];

  // contents carry no reset: software never sees stale bytes unmasked
  always @(posedge mclk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  assign rdata_out = mem[raddr_in];

endmodule

// [core/frmw_spi_rx.v]
// serial input receiver: pin synchronisers, edge detect and byte assembly
module frmw_spi_rx (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // serial pins
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  // byte stream
  output reg byte_valid_out,
  output reg [7:0] byte_out,
  output reg cs_fall_out,
  output reg cs_rise_out,
  output reg partial_out
);

  reg sck_s1, sck_s2, sck_s3;
  reg cs_s1, cs_s2, cs_s3;
  reg si_s1, si_s2;
  reg [6:0] shift;
  reg [2:0] bit_cnt;
  wire sck_rise;

  // sck and si share the same sync depth so their alignment is kept
  assign sck_rise = sck_s2 & ~sck_s3 & ~cs_s2;

  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      si_s1 <= 1'b0;
      si_s2 <= 1'b0;
      shift <= 7'h00;
      bit_cnt <= 3'h0;
      byte_valid_out <= 1'b0;
      byte_out <= 8'h00;
      cs_fall_out <= 1'b0;
      cs_rise_out <= 1'b0;
      partial_out <= 1'b0;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= cs_n_in;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      si_s1 <= si_in;
      si_s2 <= si_s1;
      byte_valid_out <= 1'b0;
      cs_fall_out <= cs_s3 & ~cs_s2;
      cs_rise_out <= ~cs_s3 & cs_s2;
      partial_out <= (~cs_s3 & cs_s2) & (bit_cnt != 3'h0);
      if (cs_s3 & ~cs_s2) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        shift <= {shift[5:0], si_s2};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_valid_out <= 1'b1;
          byte_out <= {shift, si_s2};
        end
      end
    end
  end

endmodule

// [core/frmw_top.v]
// flash command sequencer for read-modify-write, page, block and sector erase
//
// Summary of operation
// - standard rmw: 58h/59h, page then 9-bit byte
// - binary rmw: page bits 18-8, byte bits 7-0
// - data bytes fill buffer, pointer wraps
// - cs rise rewrites the whole page, received byte locations take new data
// - cs release mid-byte aborts, nothing programmed
// - operations self-timed, busy held until done
// - verify each location, set error flag
// - rmw without data does automatic page rewrite
// - standard page erase: 81h, page, dummy bits
// - binary page erase: page on address bits 18-8
// - page erase leaves every bit one
// - standard block erase: 50h, page bits 10-3
// - binary block erase: address bits 18-11, dummy bits
// - block is eight pages, low bits ignored
// - sector erase 7Ch erases one sector
// - standard sector address: page bits 10-3 or 10-8
// - binary sector address: address bits 18-11 or 18-16
// - sector decode from top page bits
`include "frmw_defs.vh"

module frmw_top #(
  parameter PAGE_W = `FRMW_PAGE_W,
  parameter BYTE_W = `FRMW_BYTE_W
) (
  // clock and reset
  input wire mclk_in,
  input wire nrst_in,
  // serial pins
  input wire sck_in,
  input wire cs_n_in,
  input wire si_in,
  // page size configuration
  input wire binary_page_mode_in,
  // array macro port
  output reg arr_req_out,
  output reg [1:0] arr_cmd_out,
  output reg [PAGE_W-1:0] arr_page_out,
  output reg [BYTE_W-1:0] arr_byte_out,
  output reg [7:0] arr_wdata_out,
  input wire arr_done_in,
  input wire [7:0] arr_rdata_in,
  // status
  output reg status_busy_out,
  output reg erase_program_error_flag_out
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_FILL = 3'h1;
  localparam S_ERASE = 3'h2;
  localparam S_EVER = 3'h3;
  localparam S_PROG = 3'h4;
  localparam S_PVER = 3'h5;
  localparam S_NEXT = 3'h6;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [`FRMW_BUF_AW-1:0] buf_index;
    input sel;
    input [BYTE_W-1:0] idx;
    begin
      buf_index = sel ? ({1'b0, idx} + {1'b0, `FRMW_PAGE_STD}) : {1'b0, idx};
    end
  endfunction

  function [BYTE_W-1:0] next_loc;
    input [BYTE_W-1:0] idx;
    input [BYTE_W-1:0] psize;
    begin
      next_loc = (idx >= psize - 9'h001) ? 9'h000 : idx + 9'h001;
    end
  endfunction

  // ----------------------------------------
  // receiver and buffers
  // ----------------------------------------
  wire byte_valid, cs_fall, cs_rise, partial;
  wire [7:0] rx_byte;
  wire [7:0] buf_rdata;
  reg buf_we;
  reg [`FRMW_BUF_AW-1:0] buf_waddr;
  reg [7:0] buf_wdata;

  frmw_spi_rx u_rx (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .byte_valid_out(byte_valid),
    .byte_out(rx_byte),
    .cs_fall_out(cs_fall),
    .cs_rise_out(cs_rise),
    .partial_out(partial)
  );

  reg mode_s1, mode_s2;
  reg [2:0] hdr_cnt;
  reg [7:0] opcode;
  reg [23:0] addr;
  reg [BYTE_W-1:0] wr_ptr;
  reg [263:0] mask;
  reg [2:0] state;
  reg buf_sel;
  reg [BYTE_W-1:0] idx;
  reg [BYTE_W-1:0] psize;
  reg [PAGE_W-1:0] cur_page;
  reg [PAGE_W-1:0] last_page;
  reg rmw_op;

  frmw_page_buf u_buf (
    .mclk_in(mclk_in),
    .we_in(buf_we),
    .waddr_in(buf_waddr),
    .wdata_in(buf_wdata),
    .raddr_in(buf_index(buf_sel, idx)),
    .rdata_out(buf_rdata)
  );

  // ----------------------------------------
  // address field decode
  // ----------------------------------------
  wire [PAGE_W-1:0] hdr_page;
  wire [BYTE_W-1:0] hdr_psize;
  wire is_rmw;
  wire op_known;
  wire frame_ok;
  wire spi_we;

  assign hdr_page = mode_s2 ? addr[`FRMW_BIN_PAGE_HI:`FRMW_BIN_PAGE_LO] :
                    addr[`FRMW_STD_PAGE_HI:`FRMW_STD_PAGE_LO];
  assign hdr_psize = mode_s2 ? `FRMW_PAGE_BIN : `FRMW_PAGE_STD;
  assign is_rmw = (opcode == `FRMW_OP_RMW_BUF1) || (opcode == `FRMW_OP_RMW_BUF2);
  assign op_known = is_rmw || (opcode == `FRMW_OP_PAGE_ERASE) || (opcode == `FRMW_OP_BLOCK_ERASE) ||
                    (opcode == `FRMW_OP_SECTOR_ERASE);
  // a busy device neither takes data into the buffers nor starts work
  assign frame_ok = cs_rise && !partial && !status_busy_out && (hdr_cnt == `FRMW_HDR_BYTES);
  assign spi_we = byte_valid && !status_busy_out && (hdr_cnt == `FRMW_HDR_BYTES) && is_rmw;

  // buffer write port: serial data while idle, array fill while running
  always @* begin
    buf_we = 1'b0;
    buf_waddr = buf_index(buf_sel, idx);
    buf_wdata = arr_rdata_in;
    if (spi_we) begin
      buf_we = 1'b1;
      buf_waddr = buf_index(opcode[0], wr_ptr);
      buf_wdata = rx_byte;
    end else if (state == S_FILL && arr_req_out && arr_done_in) begin
      buf_we = 1'b1;
    end
  end

  // ----------------------------------------
  // command capture
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      hdr_cnt <= 3'h0;
      opcode <= 8'h00;
      addr <= 24'h000000;
      wr_ptr <= 9'h000;
    end else begin
      mode_s1 <= binary_page_mode_in;
      mode_s2 <= mode_s1;
      if (cs_fall) begin
        hdr_cnt <= 3'h0;
      end else if (byte_valid && !status_busy_out) begin
        if (hdr_cnt == 3'h0) begin
          opcode <= rx_byte;
        end else if (hdr_cnt != `FRMW_HDR_BYTES) begin
          addr <= {addr[15:0], rx_byte};
        end
        if (hdr_cnt != `FRMW_HDR_BYTES) begin
          hdr_cnt <= hdr_cnt + 3'h1;
        end
        if (hdr_cnt == 3'h3) begin
          wr_ptr <= mode_s2 ? {1'b0, rx_byte} : {addr[0], rx_byte};
        end
        if (spi_we) begin
          wr_ptr <= next_loc(wr_ptr, hdr_psize);
        end
      end
    end
  end

  // ----------------------------------------
  // self-timed operation engine
  // ----------------------------------------
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      state <= S_IDLE;
      status_busy_out <= `FRMW_RST_BUSY;
      erase_program_error_flag_out <= `FRMW_RST_ERR;
      arr_req_out <= 1'b0;
      arr_cmd_out <= `FRMW_ARR_READ;
      arr_page_out <= 11'h000;
      arr_byte_out <= 9'h000;
      arr_wdata_out <= 8'h00;
      mask <= 264'h0;
      buf_sel <= 1'b0;
      idx <= 9'h000;
      psize <= `FRMW_PAGE_STD;
      cur_page <= 11'h000;
      last_page <= 11'h000;
      rmw_op <= 1'b0;
    end else begin
      if (cs_fall && !status_busy_out) begin
        mask <= 264'h0;
      end else if (spi_we) begin
        mask[wr_ptr] <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          idx <= 9'h000;
          psize <= hdr_psize;
          buf_sel <= opcode[0];
          // without data the mask stays clear, so every byte is refreshed
          if (frame_ok && op_known) begin
            rmw_op <= is_rmw;
            state <= is_rmw ? S_FILL : S_ERASE;
            status_busy_out <= 1'b1;
            erase_program_error_flag_out <= 1'b0;
            case (opcode)
              `FRMW_OP_BLOCK_ERASE: begin
                cur_page <= {hdr_page[10:3], 3'h0};
                last_page <= {hdr_page[10:3], 3'h7};
              end
              `FRMW_OP_SECTOR_ERASE: begin
                if (hdr_page[10:8] != 3'h0) begin
                  cur_page <= {hdr_page[10:8], 8'h00};
                  last_page <= {hdr_page[10:8], 8'hff};
                end else if (hdr_page[7:3] == 5'h00) begin
                  cur_page <= 11'h000;
                  last_page <= 11'h007;
                end else begin
                  cur_page <= 11'h008;
                  last_page <= 11'h0ff;
                end
              end
              default: begin
                cur_page <= hdr_page;
                last_page <= hdr_page;
              end
            endcase
          end
        end
        S_FILL: begin
          // unwritten locations are copied from the array before the erase
          if (arr_req_out) begin
            if (arr_done_in) begin
              arr_req_out <= 1'b0;
              idx <= idx + 9'h001;
            end
          end else if (idx == psize) begin
            idx <= 9'h000;
            state <= S_ERASE;
          end else if (mask[idx]) begin
            idx <= idx + 9'h001;
          end else begin
            arr_req_out <= 1'b1;
            arr_cmd_out <= `FRMW_ARR_READ;
            arr_page_out <= cur_page;
            arr_byte_out <= idx;
          end
        end
        S_ERASE: begin
          if (arr_req_out) begin
            if (arr_done_in) begin
              arr_req_out <= 1'b0;
              idx <= 9'h000;
              state <= S_EVER;
            end
          end else begin
            arr_req_out <= 1'b1;
            arr_cmd_out <= `FRMW_ARR_ERASE;
            arr_page_out <= cur_page;
            arr_byte_out <= 9'h000;
          end
        end
        S_EVER: begin
          if (arr_req_out) begin
            if (arr_done_in) begin
              arr_req_out <= 1'b0;
              idx <= idx + 9'h001;
              if (arr_rdata_in != `FRMW_ERASED_BYTE) begin
                erase_program_error_flag_out <= 1'b1;
              end
            end
          end else if (idx == psize) begin
            idx <= 9'h000;
            state <= rmw_op ? S_PROG : S_NEXT;
          end else begin
            arr_req_out <= 1'b1;
            arr_cmd_out <= `FRMW_ARR_READ;
            arr_page_out <= cur_page;
            arr_byte_out <= idx;
          end
        end
        S_PROG: begin
          if (arr_req_out) begin
            if (arr_done_in) begin
              arr_req_out <= 1'b0;
              state <= S_PVER;
            end
          end else if (idx == psize) begin
            state <= S_NEXT;
          end else begin
            arr_req_out <= 1'b1;
            arr_cmd_out <= `FRMW_ARR_PROG;
            arr_page_out <= cur_page;
            arr_byte_out <= idx;
            arr_wdata_out <= buf_rdata;
          end
        end
        S_PVER: begin
          if (arr_req_out) begin
            if (arr_done_in) begin
              arr_req_out <= 1'b0;
              idx <= idx + 9'h001;
              state <= S_PROG;
              if (arr_rdata_in != buf_rdata) begin
                erase_program_error_flag_out <= 1'b1;
              end
            end
          end else begin
            arr_req_out <= 1'b1;
            arr_cmd_out <= `FRMW_ARR_READ;
            arr_page_out <= cur_page;
            arr_byte_out <= idx;
          end
        end
        S_NEXT: begin
          idx <= 9'h000;
          if (cur_page == last_page) begin
            state <= S_IDLE;
            status_busy_out <= 1'b0;
          end else begin
            cur_page <= cur_page + 11'h001;
            state <= S_ERASE;
          end
        end
        default: begin
          state <= S_IDLE;
          arr_req_out <= 1'b0;
          status_busy_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

// [shared/frmw_defs.vh]
// constants for the flash read-modify-write and erase command sequencer
`ifndef FRMW_DEFS_VH
`define FRMW_DEFS_VH

// ----------------------------------------
// command opcodes
// ----------------------------------------
`define FRMW_OP_RMW_BUF1 8'h58
`define FRMW_OP_RMW_BUF2 8'h59
`define FRMW_OP_PAGE_ERASE 8'h81
`define FRMW_OP_BLOCK_ERASE 8'h50
`define FRMW_OP_SECTOR_ERASE 8'h7c

// ----------------------------------------
// page geometry
// ----------------------------------------
`define FRMW_PAGE_STD 9'h108
`define FRMW_PAGE_BIN 9'h100
`define FRMW_PAGE_W 11
`define FRMW_BYTE_W 9
`define FRMW_BUF_DEPTH 528
`define FRMW_BUF_AW 10
`define FRMW_HDR_BYTES 3'h4
`define FRMW_ERASED_BYTE 8'hff

// ----------------------------------------
// address field positions
// ----------------------------------------
`define FRMW_STD_PAGE_HI 19
`define FRMW_STD_PAGE_LO 9
`define FRMW_BIN_PAGE_HI 18
`define FRMW_BIN_PAGE_LO 8

// ----------------------------------------
// array port commands
// ----------------------------------------
`define FRMW_ARR_READ 2'h0
`define FRMW_ARR_PROG 2'h1
`define FRMW_ARR_ERASE 2'h2

// ----------------------------------------
// reset values
// ----------------------------------------
`define FRMW_RST_BUSY 1'b0
`define FRMW_RST_ERR 1'b0

`endif

// [sim/frmw_chk.sv]
// port checker for the flash command sequencer
`include "frmw_defs.vh"
module frmw_chk #(
  parameter PAGE_W = 11,
  parameter BYTE_W = 9
) (
  // clock, reset and chip select
  input wire mclk_in,
  input wire nrst_in,
  input wire cs_n_in,
  // array port
  input wire arr_req_out,
  input wire [1:0] arr_cmd_out,
  input wire [PAGE_W-1:0] arr_page_out,
  input wire [BYTE_W-1:0] arr_byte_out,
  input wire [7:0] arr_wdata_out,
  input wire arr_done_in,
  // status
  input wire status_busy_out,
  input wire erase_program_error_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_wait;
    arr_req_out && !arr_done_in;
  endsequence
  sequence s_erase_done;
    arr_req_out && arr_done_in && arr_cmd_out == `FRMW_ARR_ERASE;
  endsequence
  sequence s_verify_start;
    ##[1:3] arr_req_out && arr_cmd_out == `FRMW_ARR_READ && arr_byte_out == 0;
  endsequence
  chk_req_held: assert property (s_wait |=> arr_req_out && $stable(arr_cmd_out) && $stable(arr_page_out)
    && $stable(arr_byte_out) && $stable(arr_wdata_out)) else $error("array request changed before done");
  chk_req_drop: assert property (arr_req_out && arr_done_in |=> !arr_req_out)
    else $error("array request held after done");
  chk_req_busy: assert property (arr_req_out |-> status_busy_out)
    else $error("array request while ready");
  chk_busy_start: assert property ($rose(status_busy_out) |-> cs_n_in && $past(cs_n_in, 3))
    else $error("busy rose without chip select release");
  chk_busy_end: assert property ($fell(status_busy_out) |-> !arr_req_out)
    else $error("ready while array request open");
  chk_erase_verify: assert property (s_erase_done |=> s_verify_start)
    else $error("erase not followed by verify from byte zero");
  chk_err_clear: assert property ($rose(status_busy_out) |-> ##[0:1] !erase_program_error_flag_out)
    else $error("error flag not cleared at start");
  chk_err_busy: assert property ($rose(erase_program_error_flag_out) |-> status_busy_out)
    else $error("error flag set while ready");
  chk_reset_idle: assert property (@(posedge mclk_in) disable iff (1'b0) !nrst_in |=> !arr_req_out
    && !status_busy_out && !erase_program_error_flag_out) else $error("outputs not idle in reset");
endmodule
bind frmw_top frmw_chk #(.PAGE_W(PAGE_W), .BYTE_W(BYTE_W)) i_frmw_chk (.mclk_in(mclk_in), .nrst_in(nrst_in),
  .cs_n_in(cs_n_in), .arr_req_out(arr_req_out), .arr_cmd_out(arr_cmd_out), .arr_page_out(arr_page_out),
  .arr_byte_out(arr_byte_out), .arr_wdata_out(arr_wdata_out), .arr_done_in(arr_done_in),
  .status_busy_out(status_busy_out), .erase_program_error_flag_out(erase_program_error_flag_out));

// [sim/frmw_host.sv]
// host serial controller model sending command frames, mode 0
module frmw_host (
  // serial pins
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // msb first; extra bits model a release in mid-byte
  task automatic frame(input logic [7:0] q [$], input int extra);
    logic [7:0] b;
    int n;
    n = 8 * q.size() + extra;
    cs_n_out = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      b = (i / 8 < q.size()) ? q[i / 8] : 8'ha5;
      si_out = b[7 - i % 8];
      #62.5 sck_out = 1'b1;
      #62.5 sck_out = 1'b0;
    end
    #60 cs_n_out = 1'b1;
    // released line must not keep the last bit
    si_out = ~si_out;
  endtask
endmodule

// [sim/frmw_top_test.sv]
// self-checking bench for the flash command sequencer
`include "frmw_defs.vh"
module frmw_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] frmw_bq_t [$];
  logic mclk_in, nrst_in, binary_page_mode_in, arr_done_in, fault;
  logic [7:0] arr_rdata_in;
  wire sck, cs_n, si, arr_req_out, status_busy_out, erase_program_error_flag_out;
  wire [1:0] arr_cmd_out;
  wire [10:0] arr_page_out;
  wire [8:0] arr_byte_out;
  wire [7:0] arr_wdata_out;
  int n_mismatch, checks, cnt;
  logic [7:0] mem [int];
  int erased [$];
  frmw_host i_frmw_host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  frmw_top i_frmw_top (.mclk_in(mclk_in), .nrst_in(nrst_in), .sck_in(sck), .cs_n_in(cs_n), .si_in(si),
    .binary_page_mode_in(binary_page_mode_in), .arr_req_out(arr_req_out), .arr_cmd_out(arr_cmd_out),
    .arr_page_out(arr_page_out), .arr_byte_out(arr_byte_out), .arr_wdata_out(arr_wdata_out),
    .arr_done_in(arr_done_in), .arr_rdata_in(arr_rdata_in), .status_busy_out(status_busy_out),
    .erase_program_error_flag_out(erase_program_error_flag_out));
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // ----------------------------------------
  // array macro model, unwritten bytes read 00
  // ----------------------------------------
  function automatic logic [7:0] rd(input int p, input int b);
    return mem.exists(p * 512 + b) ? mem[p * 512 + b] : 8'h00;
  endfunction
  always @(posedge mclk_in) begin
    cnt <= (!arr_req_out || arr_done_in) ? 0 : cnt + 1;
    arr_done_in <= arr_req_out && !arr_done_in && cnt == 1;
    if (arr_req_out && !arr_done_in && cnt == 1) begin
      if (arr_cmd_out == `FRMW_ARR_ERASE) begin
        erased.push_back(arr_page_out);
        for (int b = 0; b < 264; b++) mem[arr_page_out * 512 + b] = `FRMW_ERASED_BYTE;
      end
      if (arr_cmd_out == `FRMW_ARR_PROG) mem[arr_page_out * 512 + arr_byte_out] = arr_wdata_out;
      // fault corrupts every read so verify must fail
      arr_rdata_in <= fault ? 8'h00 : rd(arr_page_out, arr_byte_out);
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic frmw_bq_t cmd(input logic [7:0] opc, input logic [23:0] a);
    return '{opc, a[23:16], a[15:8], a[7:0]};
  endfunction
  task automatic op(input frmw_bq_t q, input int extra, input logic exp_busy);
    int i;
    erased.delete();
    i_frmw_host.frame(q, extra);
    i = 0;
    while (status_busy_out !== 1'b1 && i < 20) begin
      @(negedge mclk_in);
      i++;
    end
    chk("busy after release", exp_busy, status_busy_out);
    i = 0;
    while (status_busy_out !== 1'b0 && i < 100000) begin
      @(negedge mclk_in);
      i++;
    end
    chk("busy at end", 0, status_busy_out);
  endtask
  task automatic fill(input int p);
    for (int b = 0; b < 264; b++) mem[p * 512 + b] = b[7:0] ^ 8'h3c;
  endtask
  task automatic chk_page(input int p, input int size, input int st, input int n);
    logic [7:0] e;
    for (int b = 0; b < size; b++) begin
      e = b[7:0] ^ 8'h3c;
      for (int k = 0; k < n; k++) if ((st + k) % size == b) e = 8'hd0 + k[7:0];
      chk("page byte", e, rd(p, b));
    end
  endtask
  // a rewrite leaves the last byte at its old value, an erase leaves it all ones
  task automatic chk_erased(input int first, input int n, input logic [7:0] last = 8'hff);
    chk("erased page count", n, erased.size());
    for (int i = 0; i < n && i < erased.size(); i++) chk("erased page", first + i, erased[i]);
    chk("erased byte", last, rd(first, 263));
  endtask
  task automatic rmw(input logic bin, input logic [7:0] opc, input int p, input int st, input int n,
      input int extra);
    frmw_bq_t q;
    binary_page_mode_in = bin;
    fill(p);
    q = cmd(opc, bin ? (p << 8) | st : (p << 9) | st);
    for (int k = 0; k < n; k++) q.push_back(8'hd0 + k[7:0]);
    op(q, extra, extra == 0);
    chk_page(p, bin ? 256 : 264, st, extra == 0 ? n : 0);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_erase_cmds;
    binary_page_mode_in = 1'b0;
    op(cmd(`FRMW_OP_PAGE_ERASE, (12 << 9) | 9'h1ff), 0, 1);
    chk_erased(12, 1);
    op(cmd(`FRMW_OP_BLOCK_ERASE, (5 << 12) | 12'hfff), 0, 1);
    chk_erased(40, 8);
    op(cmd(`FRMW_OP_SECTOR_ERASE, 24'h000fff), 0, 1);
    chk_erased(0, 8);
    binary_page_mode_in = 1'b1;
    op(cmd(`FRMW_OP_PAGE_ERASE, (13 << 8) | 8'hff), 0, 1);
    chk_erased(13, 1);
    op(cmd(`FRMW_OP_BLOCK_ERASE, (6 << 11) | 11'h7ff), 0, 1);
    chk_erased(48, 8);
  endtask
  task t_sector_reset;
    int i;
    binary_page_mode_in = 1'b1;
    erased.delete();
    i_frmw_host.frame(cmd(`FRMW_OP_SECTOR_ERASE, 24'h03ffff), 0);
    i = 0;
    while (erased.size() == 0 && i < 100) begin
      @(negedge mclk_in);
      i++;
    end
    chk("sector first page", 768, erased.size() ? erased[0] : 0);
    // sector 3 is 256 pages, too long to finish; reset cuts it
    nrst_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    chk("busy after reset", 0, status_busy_out);
    repeat (4) @(negedge mclk_in);
  endtask
  task t_error_and_busy;
    // the sector scenario left binary mode on; these addresses are standard
    binary_page_mode_in = 1'b0;
    fault = 1'b1;
    op(cmd(`FRMW_OP_PAGE_ERASE, 20 << 9), 0, 1);
    chk("error flag", 1, erase_program_error_flag_out);
    fault = 1'b0;
    fill(21);
    fork
      op(cmd(`FRMW_OP_RMW_BUF1, 21 << 9), 0, 1);
      begin
        #5000;
        i_frmw_host.frame(cmd(`FRMW_OP_PAGE_ERASE, 22 << 9), 0);
      end
    join
    chk_erased(21, 1, 8'h3b);
    chk_page(21, 264, 0, 0);
    chk("error flag", 0, erase_program_error_flag_out);
  endtask
  task t_rmw;
    rmw(1'b0, `FRMW_OP_RMW_BUF1, 3, 262, 3, 0);
    rmw(1'b1, `FRMW_OP_RMW_BUF2, 291, 255, 2, 0);
    rmw(1'b0, `FRMW_OP_RMW_BUF1, 9, 0, 1, 3);
  endtask
  // all scenarios need about 220 us; the limit leaves margin under 100k cycles
  initial begin
    #350us;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    nrst_in = 1'b0;
    binary_page_mode_in = 1'b0;
    arr_done_in = 1'b0;
    arr_rdata_in = 8'h00;
    fault = 1'b0;
    cnt = 0;
    repeat (2) @(negedge mclk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    t_rmw();
    t_erase_cmds();
    t_sector_reset();
    t_error_and_busy();
    end_of_test();
  end
endmodule
